// file: hw/checksum_offload_pkg.sv
package checksum_offload_pkg;

    // Register map (byte addresses)
    localparam int unsigned ADDR_W             = 12;
    localparam logic [11:0] CTRL_OFFSET        = 12'h130;
    localparam logic [11:0] STATUS_OFFSET      = 12'h134;
    localparam logic [11:0] RX_FRAMES_OFFSET   = 12'h138;
    localparam logic [11:0] TX_FRAMES_OFFSET   = 12'h13C;
    localparam logic [11:0] VLAN_TAGS_OFFSET   = 12'h140;
    localparam logic [11:0] SNAP_FRAMES_OFFSET = 12'h144;

    // Control register fields
    localparam int unsigned RX_ENABLE_BIT      = 0;
    localparam int unsigned RX_START_MODE_BIT  = 1;
    localparam int unsigned TX_ENABLE_BIT      = 16;
    localparam logic        RX_ENABLE_RESET    = 1'b0;
    localparam logic        RX_START_MODE_RESET = 1'b0;
    localparam logic        TX_ENABLE_RESET    = 1'b0;

    // Status register fields
    localparam int unsigned ST_RX_IN_FRAME_BIT = 0;
    localparam int unsigned ST_TX_IN_FRAME_BIT = 1;
    localparam int unsigned ST_RX_EN_BIT       = 2;
    localparam int unsigned ST_RX_MODE_BIT     = 3;
    localparam int unsigned ST_TX_EN_BIT       = 4;
    localparam int unsigned ST_UNSAFE_BIT      = 8;
    localparam logic [15:0] COUNT_RESET        = 16'h0000;

    // Frame layout
    localparam logic [3:0]  FIXED_START_BYTES  = 4'hE;   // Type field ends before byte 14
    localparam logic [3:0]  MAC_HDR_LAST       = 4'hB;   // Last address byte, index 11
    localparam logic [3:0]  VLAN_TCI_LAST      = 4'h1;
    localparam logic [3:0]  LLC_LAST           = 4'h2;
    localparam logic [3:0]  SNAP_REST_LAST     = 4'h4;   // OUI plus protocol id
    localparam logic [15:0] TPID_CTAG          = 16'h8100;
    localparam logic [15:0] TPID_STAG          = 16'h88A8;
    localparam logic [15:0] LENGTH_LIMIT       = 16'h0600;
    localparam logic [7:0]  LLC_SNAP_SAP       = 8'hAA;
    localparam logic [7:0]  LLC_UI_CTRL        = 8'h03;

    typedef struct packed {
        logic [7:0] data;
        logic       sof;
        logic       eof;
    } beat_type;

    typedef struct packed {
        logic tx_offload_enable;
        logic rx_offload_start_mode;
        logic rx_offload_enable;
    } settings_type;

    typedef enum logic [2:0] {
        P_MAC      = 3'b000,
        P_TYPE_HI  = 3'b001,
        P_TYPE_LO  = 3'b010,
        P_VLAN_TCI = 3'b011,
        P_LLC      = 3'b100,
        P_SNAP     = 3'b101,
        P_BODY     = 3'b110
    } parse_state_type;

endpackage

// file: hw/frame_settings_latch.sv
`timescale 1ns/1ps
module frame_settings_latch
    import checksum_offload_pkg::*;
(
    input  wire logic         clk_sys,   // System clock
    input  wire logic         rst,       // Synchronous reset
    input  wire settings_type live,      // Settings as software last wrote them
    input  wire logic         valid,     // Beat present
    input  wire logic         sof,       // First beat of frame
    input  wire logic         eof,       // Last beat of frame
    output      settings_type effective, // Settings governing the current beat
    output      logic         in_frame   // Between first and last beat
);

    settings_type held;
    settings_type next_held;
    logic         next_in_frame;

    // First beat takes the live value, the rest of the frame the held copy
    assign effective = (valid && sof) ? live : held;

    always_comb begin
        next_held     = held;
        next_in_frame = in_frame;
        if (valid && sof) begin
            next_held     = live;
            next_in_frame = 1'b1;
        end
        if (valid && eof) begin
            next_in_frame = 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            held     <= '0;
            in_frame <= 1'b0;
        end else begin
            held     <= next_held;
            in_frame <= next_in_frame;
        end
    end

endmodule // frame_settings_latch

// file: hw/l3_start_finder.sv
`timescale 1ns/1ps
module l3_start_finder
    import checksum_offload_pkg::*;
(
    input  wire logic     clk_sys,    // System clock
    input  wire logic     rst,        // Synchronous reset
    input  wire beat_type beat,       // Receive beat
    input  wire logic     valid,      // Beat present
    input  wire logic     start_mode, // 0 fixed offset, 1 follow headers
    output      logic     in_body,    // Current beat lies in the summed region
    output      logic     vlan_hit,   // Current beat completes a VLAN TPID
    output      logic     snap_hit    // Current beat completes a SNAP LLC
);

    parse_state_type state;
    parse_state_type next_state;
    parse_state_type cur;
    logic [3:0]      cnt;
    logic [3:0]      next_cnt;
    logic [3:0]      cur_cnt;
    logic [7:0]      type_hi;
    logic [7:0]      next_type_hi;
    logic            snap_ok;
    logic            next_snap_ok;
    logic [15:0]     type_word;

    function automatic logic [7:0] llc_byte(input logic [3:0] idx);
        return (idx == LLC_LAST) ? LLC_UI_CTRL : LLC_SNAP_SAP;
    endfunction

    // A new frame restarts the walk even if the last one lost its end marker
    assign cur       = beat.sof ? P_MAC : state;
    assign cur_cnt   = beat.sof ? 4'h0 : cnt;
    assign type_word = {type_hi, beat.data};
    assign in_body   = valid && (cur == P_BODY);

    always_comb begin
        next_state   = state;
        next_cnt     = cnt;
        next_type_hi = type_hi;
        next_snap_ok = snap_ok;
        vlan_hit     = 1'b0;
        snap_hit     = 1'b0;
        if (valid) begin
            next_state = cur;
            next_cnt   = cur_cnt + 4'h1;
            unique case (cur)
                P_MAC: if (cur_cnt == MAC_HDR_LAST) begin
                    next_state = P_TYPE_HI;
                    next_cnt   = 4'h0;
                end
                P_TYPE_HI: begin
                    next_type_hi = beat.data;
                    next_state   = P_TYPE_LO;
                end
                P_TYPE_LO: begin
                    next_cnt     = 4'h0;
                    next_snap_ok = 1'b1;
                    if (!start_mode) begin
                        next_state = P_BODY;
                    end else if (type_word == TPID_CTAG || type_word == TPID_STAG) begin
                        next_state = P_VLAN_TCI;
                        vlan_hit   = 1'b1;
                    end else if (type_word < LENGTH_LIMIT) begin
                        next_state = P_LLC;
                    end else begin
                        next_state = P_BODY;
                    end
                end
                P_VLAN_TCI: if (cur_cnt == VLAN_TCI_LAST) begin
                    next_state = P_TYPE_HI;
                    next_cnt   = 4'h0;
                end
                P_LLC: begin
                    next_snap_ok = snap_ok && (beat.data == llc_byte(cur_cnt));
                    if (cur_cnt == LLC_LAST) begin
                        next_cnt = 4'h0;
                        // Plain 802.2 frames carry L3 straight after the LLC
                        if (next_snap_ok) begin
                            next_state = P_SNAP;
                            snap_hit   = 1'b1;
                        end else begin
                            next_state = P_BODY;
                        end
                    end
                end
                P_SNAP: if (cur_cnt == SNAP_REST_LAST) begin
                    next_state = P_BODY;
                end
                P_BODY: next_cnt = cnt;
                default: next_state = P_MAC;
            endcase
            if (beat.eof) begin
                next_state = P_MAC;
                next_cnt   = 4'h0;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state   <= P_MAC;
            cnt     <= 4'h0;
            type_hi <= 8'h00;
            snap_ok <= 1'b0;
        end else begin
            state   <= next_state;
            cnt     <= next_cnt;
            type_hi <= next_type_hi;
            snap_ok <= next_snap_ok;
        end
    end

endmodule // l3_start_finder

// file: hw/checksum_offload_control.sv
// Summary of operation
// - Bit 16 enables transmit checksum insertion
// - Bit 0 enables receive checksum calculation
// - Mode 0: summing starts at byte 14
// - Mode 1: skip VLAN tags, SNAP headers
`timescale 1ns/1ps
module checksum_offload_control
    import checksum_offload_pkg::*;
(
    input  wire logic        clk_sys,          // System clock, 200 MHz
    input  wire logic        rst,              // Synchronous reset, active high
    input  wire logic [11:0] reg_addr,         // Register byte address
    input  wire logic [31:0] reg_wdata,        // Register write data
    input  wire logic        reg_write,        // Write strobe
    input  wire logic        reg_read,         // Read strobe
    output      logic [31:0] reg_rdata,        // Read data, cycle after strobe
    input  wire beat_type    rx_in,            // Receive beat from MAC
    input  wire logic        rx_in_valid,      // Receive beat present
    output      beat_type    rx_out,           // Receive beat to engine
    output      logic        rx_out_valid,     // Receive beat present
    output      logic        rx_sum_enable,    // Beat belongs to checksum region
    output      logic        rx_engine_active, // Receive engine enabled this frame
    input  wire beat_type    tx_in,            // Transmit beat from buffer
    input  wire logic        tx_in_valid,      // Transmit beat present
    output      beat_type    tx_out,           // Transmit beat to engine
    output      logic        tx_out_valid,     // Transmit beat present
    output      logic        tx_insert_enable  // Engine inserts checksum this frame
);

    settings_type cfg;
    settings_type next_cfg;
    settings_type rx_eff;
    settings_type tx_eff;
    logic         rx_in_frame;
    logic         tx_in_frame;
    logic         rx_body;
    logic         rx_vlan_hit;
    logic         rx_snap_hit;
    logic         unsafe_change;
    logic         next_unsafe_change;
    logic [15:0]  rx_frames;
    logic [15:0]  next_rx_frames;
    logic [15:0]  tx_frames;
    logic [15:0]  next_tx_frames;
    logic [15:0]  vlan_tags;
    logic [15:0]  next_vlan_tags;
    logic [15:0]  snap_frames;
    logic [15:0]  next_snap_frames;
    logic [31:0]  next_reg_rdata;
    beat_type     next_rx_out;
    logic         next_rx_out_valid;
    logic         next_rx_sum_enable;
    logic         next_rx_engine_active;
    beat_type     next_tx_out;
    logic         next_tx_out_valid;
    logic         next_tx_insert_enable;
    logic         ctrl_write;
    logic         status_write;

    function automatic logic [31:0] ctrl_image(input settings_type s);
        logic [31:0] w;
        w                    = 32'h0000_0000;
        w[TX_ENABLE_BIT]     = s.tx_offload_enable;
        w[RX_START_MODE_BIT] = s.rx_offload_start_mode;
        w[RX_ENABLE_BIT]     = s.rx_offload_enable;
        return w;
    endfunction

    function automatic settings_type ctrl_fields(input logic [31:0] w);
        settings_type s;
        s.tx_offload_enable     = w[TX_ENABLE_BIT];
        s.rx_offload_start_mode = w[RX_START_MODE_BIT];
        s.rx_offload_enable     = w[RX_ENABLE_BIT];
        return s;
    endfunction

    // Each path freezes its settings from its own first beat to its last
    frame_settings_latch rx_latch (
        .clk_sys   (clk_sys),
        .rst       (rst),
        .live      (cfg),
        .valid     (rx_in_valid),
        .sof       (rx_in.sof),
        .eof       (rx_in.eof),
        .effective (rx_eff),
        .in_frame  (rx_in_frame)
    );

    frame_settings_latch tx_latch (
        .clk_sys   (clk_sys),
        .rst       (rst),
        .live      (cfg),
        .valid     (tx_in_valid),
        .sof       (tx_in.sof),
        .eof       (tx_in.eof),
        .effective (tx_eff),
        .in_frame  (tx_in_frame)
    );

    l3_start_finder rx_finder (
        .clk_sys    (clk_sys),
        .rst        (rst),
        .beat       (rx_in),
        .valid      (rx_in_valid),
        .start_mode (rx_eff.rx_offload_start_mode),
        .in_body    (rx_body),
        .vlan_hit   (rx_vlan_hit),
        .snap_hit   (rx_snap_hit)
    );

    assign ctrl_write   = reg_write && (reg_addr == CTRL_OFFSET);
    assign status_write = reg_write && (reg_addr == STATUS_OFFSET);

    // Control register and the check on software's change discipline
    always_comb begin
        next_cfg           = cfg;
        next_unsafe_change = unsafe_change;
        if (status_write && reg_wdata[ST_UNSAFE_BIT]) begin
            next_unsafe_change = 1'b0;
        end
        if (ctrl_write) begin
            next_cfg = ctrl_fields(reg_wdata);
            // The new value still waits for the next frame; the flag only
            // tells software it broke the idle-path precondition
            if ((rx_in_frame && (next_cfg.rx_offload_enable != cfg.rx_offload_enable ||
                 next_cfg.rx_offload_start_mode != cfg.rx_offload_start_mode)) ||
                (tx_in_frame && next_cfg.tx_offload_enable != cfg.tx_offload_enable)) begin
                next_unsafe_change = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            cfg.tx_offload_enable     <= TX_ENABLE_RESET;
            cfg.rx_offload_start_mode <= RX_START_MODE_RESET;
            cfg.rx_offload_enable     <= RX_ENABLE_RESET;
            unsafe_change             <= 1'b0;
        end else begin
            cfg           <= next_cfg;
            unsafe_change <= next_unsafe_change;
        end
    end

    // Frame paths: one register stage, data never altered here
    always_comb begin
        next_rx_out           = rx_in;
        next_rx_out_valid     = rx_in_valid;
        next_rx_sum_enable    = rx_in_valid && rx_eff.rx_offload_enable && rx_body;
        next_rx_engine_active = rx_in_valid ? rx_eff.rx_offload_enable : rx_engine_active;
        next_tx_out           = tx_in;
        next_tx_out_valid     = tx_in_valid;
        next_tx_insert_enable = tx_in_valid ? tx_eff.tx_offload_enable : 1'b0;
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            rx_out           <= '0;
            rx_out_valid     <= 1'b0;
            rx_sum_enable    <= 1'b0;
            rx_engine_active <= 1'b0;
            tx_out           <= '0;
            tx_out_valid     <= 1'b0;
            tx_insert_enable <= 1'b0;
        end else begin
            rx_out           <= next_rx_out;
            rx_out_valid     <= next_rx_out_valid;
            rx_sum_enable    <= next_rx_sum_enable;
            rx_engine_active <= next_rx_engine_active;
            tx_out           <= next_tx_out;
            tx_out_valid     <= next_tx_out_valid;
            tx_insert_enable <= next_tx_insert_enable;
        end
    end

    // Activity counters, wrapping; only frames the engines actually handle
    always_comb begin
        next_rx_frames   = rx_frames;
        next_tx_frames   = tx_frames;
        next_vlan_tags   = vlan_tags;
        next_snap_frames = snap_frames;
        if (rx_in_valid && rx_in.sof && rx_eff.rx_offload_enable) begin
            next_rx_frames = rx_frames + 16'h0001;
        end
        if (tx_in_valid && tx_in.sof && tx_eff.tx_offload_enable) begin
            next_tx_frames = tx_frames + 16'h0001;
        end
        if (rx_vlan_hit && rx_eff.rx_offload_enable) begin
            next_vlan_tags = vlan_tags + 16'h0001;
        end
        if (rx_snap_hit && rx_eff.rx_offload_enable) begin
            next_snap_frames = snap_frames + 16'h0001;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            rx_frames   <= COUNT_RESET;
            tx_frames   <= COUNT_RESET;
            vlan_tags   <= COUNT_RESET;
            snap_frames <= COUNT_RESET;
        end else begin
            rx_frames   <= next_rx_frames;
            tx_frames   <= next_tx_frames;
            vlan_tags   <= next_vlan_tags;
            snap_frames <= next_snap_frames;
        end
    end

    // Read data stands only in the cycle after the strobe, zero otherwise
    always_comb begin
        next_reg_rdata = 32'h0000_0000;
        if (reg_read) begin
            unique case (reg_addr)
                CTRL_OFFSET: next_reg_rdata = ctrl_image(cfg);
                STATUS_OFFSET: begin
                    next_reg_rdata[ST_RX_IN_FRAME_BIT] = rx_in_frame;
                    next_reg_rdata[ST_TX_IN_FRAME_BIT] = tx_in_frame;
                    next_reg_rdata[ST_RX_EN_BIT]       = rx_eff.rx_offload_enable;
                    next_reg_rdata[ST_RX_MODE_BIT]     = rx_eff.rx_offload_start_mode;
                    next_reg_rdata[ST_TX_EN_BIT]       = tx_eff.tx_offload_enable;
                    next_reg_rdata[ST_UNSAFE_BIT]      = unsafe_change;
                end
                RX_FRAMES_OFFSET:   next_reg_rdata = {16'h0000, rx_frames};
                TX_FRAMES_OFFSET:   next_reg_rdata = {16'h0000, tx_frames};
                VLAN_TAGS_OFFSET:   next_reg_rdata = {16'h0000, vlan_tags};
                SNAP_FRAMES_OFFSET: next_reg_rdata = {16'h0000, snap_frames};
                default:            next_reg_rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            reg_rdata <= 32'h0000_0000;
        end else begin
            reg_rdata <= next_reg_rdata;
        end
    end

endmodule // checksum_offload_control

// file: bench/checksum_offload_props.sv
`timescale 1ns/1ps
module checksum_offload_props
    import checksum_offload_pkg::*;
(
    input wire logic        clk_sys, // Clock
    input wire logic        rst, // Reset
    input wire logic [11:0] reg_addr, // Address
    input wire logic [31:0] reg_wdata, // Write data
    input wire logic        reg_write, // Write strobe
    input wire logic        reg_read, // Read strobe
    input wire logic [31:0] reg_rdata, // Read data
    input wire beat_type    rx_in, // Rx beat in
    input wire logic        rx_in_valid, // Rx in valid
    input wire beat_type    rx_out, // Rx beat out
    input wire logic        rx_out_valid, // Rx out valid
    input wire logic        rx_sum_enable, // Summed
    input wire logic        rx_engine_active, // Rx engine on
    input wire beat_type    tx_in, // Tx beat in
    input wire logic        tx_in_valid, // Tx in valid
    input wire beat_type    tx_out, // Tx beat out
    input wire logic        tx_out_valid, // Tx out valid
    input wire logic        tx_insert_enable // Insert on
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    settings_type shadow;
    settings_type rx_eff;
    settings_type tx_eff;
    logic [15:0]  rx_idx;
    logic [15:0]  rx_cnt;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            shadow <= '0;
            rx_eff <= '0;
            tx_eff <= '0;
            rx_idx <= '0;
            rx_cnt <= '0;
        end else begin
            if (reg_write && reg_addr == CTRL_OFFSET) begin
                shadow <= '{reg_wdata[TX_ENABLE_BIT], reg_wdata[RX_START_MODE_BIT],
                            reg_wdata[RX_ENABLE_BIT]};
            end
            if (rx_in_valid) begin
                rx_idx <= rx_in.sof ? 16'h0000 : rx_cnt;
                rx_cnt <= rx_in.sof ? 16'h0001 : rx_cnt + 16'h0001;
                if (rx_in.sof) rx_eff <= shadow;
            end
            if (tx_in_valid && tx_in.sof) tx_eff <= shadow;
        end
    end

    a_rx_beat_delay: assert property (rx_in_valid |=> rx_out_valid && rx_out == $past(rx_in))
        else $error("rx beat late");
    a_rx_gap_quiet: assert property (!rx_in_valid |=> !rx_out_valid && !rx_sum_enable)
        else $error("rx out idle");
    a_bypass_no_sum: assert property (
        rx_out_valid && !rx_eff.rx_offload_enable |-> !rx_sum_enable)
        else $error("rx bypass sum");
    a_engine_per_frame: assert property (
        rx_out_valid |-> rx_engine_active == rx_eff.rx_offload_enable)
        else $error("rx engine state");
    a_fixed_offset: assert property (
        rx_out_valid && rx_eff.rx_offload_enable && !rx_eff.rx_offload_start_mode
        |-> rx_sum_enable == (rx_idx >= {12'h000, FIXED_START_BYTES}))
        else $error("fixed offset");
    a_header_unsummed: assert property (
        rx_out_valid && rx_idx < 16'h000E |-> !rx_sum_enable)
        else $error("header summed");
    a_tx_per_frame: assert property (
        tx_out_valid |-> tx_insert_enable == tx_eff.tx_offload_enable)
        else $error("tx insert state");
    a_tx_beat_delay: assert property (tx_in_valid |=> tx_out_valid ##0 tx_out == $past(tx_in))
        else $error("tx beat late");
    a_tx_idle_off: assert property (!tx_out_valid |-> !tx_insert_enable)
        else $error("tx idle insert");
    a_ctrl_readback: assert property (
        reg_read && reg_addr == CTRL_OFFSET |=> reg_rdata == {15'h0000,
        shadow.tx_offload_enable, 14'h0000, shadow.rx_offload_start_mode,
        shadow.rx_offload_enable})
        else $error("ctrl readback");
    a_rdata_idle: assert property (!reg_read |=> reg_rdata == 32'h0000_0000)
        else $error("rdata idle");

    c_follow_headers: cover property (rx_sum_enable && rx_eff.rx_offload_start_mode);
    c_tx_insert: cover property (tx_insert_enable);
    c_ctrl_read: cover property (reg_read && reg_addr == CTRL_OFFSET);
endmodule // checksum_offload_props

bind checksum_offload_control checksum_offload_props u_props (.*);

// file: bench/mac_path_model.sv
`timescale 1ns/1ps
module mac_path_model
    import checksum_offload_pkg::*;
(
    input  wire logic     clk_sys,     // System clock
    output      beat_type rx_in,       // Beat from the receive path
    output      logic     rx_in_valid, // Receive beat present
    output      beat_type tx_in,       // Beat from the transmit buffer
    output      logic     tx_in_valid  // Transmit beat present
);
    initial {rx_in, rx_in_valid, tx_in, tx_in_valid} = '0;

    task automatic send(input logic to_tx, input logic [7:0] bytes[$]);
        beat_type b;
        for (int i = 0; i < bytes.size(); i++) begin
            b = '{data: bytes[i], sof: i == 0, eof: i == bytes.size() - 1};
            @(posedge clk_sys);
            if (to_tx) begin
                tx_in <= b;
                tx_in_valid <= 1'b1;
            end else begin
                rx_in <= b;
                rx_in_valid <= 1'b1;
            end
        end
        @(posedge clk_sys);
        // Idle lines show garbage so nothing leans on a stale beat
        b = ~b;
        if (to_tx) begin
            tx_in <= b;
            tx_in_valid <= 1'b0;
        end else begin
            rx_in <= b;
            rx_in_valid <= 1'b0;
        end
    endtask
endmodule // mac_path_model

// file: bench/checksum_offload_control_test.sv
`timescale 1ns/1ps
module checksum_offload_control_test
    import checksum_offload_pkg::*;
;
    logic        clk_sys;
    logic        rst;
    logic [11:0] reg_addr = '0;
    logic [31:0] reg_wdata = '0;
    logic        reg_write = 1'b0;
    logic        reg_read = 1'b0;
    logic [31:0] reg_rdata;
    beat_type    rx_in, rx_out, tx_in, tx_out;
    logic        rx_in_valid, rx_out_valid, rx_sum_enable, rx_engine_active;
    logic        tx_in_valid, tx_out_valid, tx_insert_enable;
    int          mismatches, cmp_count, sum_cnt, first_idx, rx_idx, ins_cnt;
    logic [31:0] rd;
    logic [7:0]  frame[$];
    logic [95:0] hdrs [6] = '{96'h0800_0000_0000_0000_0000_0000,
        96'h8100_0005_0800_0000_0000_0000, 96'h88A8_0001_8100_0002_0800_0000,
        96'h0028_AAAA_0300_0000_0800_0000, 96'h0028_4242_0300_0000_0000_0000,
        96'h8100_0005_0800_0000_0000_0000};
    int          nhdr [6] = '{2, 6, 10, 10, 5, 6};
    int          starts [6] = '{14, 18, 22, 22, 17, 14};
    logic [31:0] counts [4] = '{32'h0000_0007, 32'h0000_0001, 32'h0000_0003, 32'h0000_0001};

    checksum_offload_control u_dut (.*);
    mac_path_model u_mac (.*);

    initial clk_sys = 1'b0;
    always #2.5 clk_sys = ~clk_sys;

    always @(posedge clk_sys) begin
        if (rx_out_valid === 1'b1) begin
            rx_idx = (rx_out.sof === 1'b1) ? 0 : rx_idx + 1;
            if (rx_sum_enable === 1'b1) begin
                if (sum_cnt == 0) first_idx = rx_idx;
                sum_cnt++;
            end
        end
        if (tx_out_valid === 1'b1 && tx_insert_enable === 1'b1) ins_cnt++;
    end

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic summarize;
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    task automatic reg_wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_write <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_write <= 1'b0;
    endtask

    task automatic reg_rd(input logic [11:0] a, output logic [31:0] d);
        @(posedge clk_sys);
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_read <= 1'b0;
        #1;
        d = reg_rdata;
    endtask

    task automatic make_frame(input logic [95:0] hdr, input int n, input int len);
        frame.delete();
        for (int i = 0; i < 12; i++) frame.push_back(8'h10 + 8'(i));
        for (int i = 0; i < n; i++) frame.push_back(hdr[95 - 8 * i -: 8]);
        while (frame.size() < len) frame.push_back(8'h5A);
    endtask

    task automatic run_frame(input logic to_tx);
        sum_cnt = 0;
        ins_cnt = 0;
        u_mac.send(to_tx, frame);
        repeat (3) @(posedge clk_sys);
    endtask

    initial begin
        repeat (50000) @(posedge clk_sys);
        mismatches++;
        summarize();
    end

    initial begin
        rst = 1'b1;
        repeat (5) @(posedge clk_sys);
        rst <= 1'b0;
        reg_rd(CTRL_OFFSET, rd);
        check("ctrl reset", rd, 32'h0000_0000);
        reg_wr(CTRL_OFFSET, 32'hFFFF_FFFF);
        reg_rd(CTRL_OFFSET, rd);
        check("ctrl fields", rd, 32'h0001_0003);
        reg_wr(12'h12C, 32'h0000_0000);
        reg_rd(12'h12C, rd);
        check("unmapped read", rd, 32'h0000_0000);
        reg_rd(CTRL_OFFSET, rd);
        check("ctrl after stray write", rd, 32'h0001_0003);
        for (int k = 0; k < 6; k++) begin
            reg_wr(CTRL_OFFSET, (k == 5) ? 32'h0000_0001 : 32'h0000_0003);
            make_frame(hdrs[k], nhdr[k], starts[k] + 6);
            run_frame(1'b0);
            check("rx sum start", 32'(first_idx), 32'(starts[k]));
            check("rx sum count", 32'(sum_cnt), 32'h0000_0006);
        end
        reg_wr(CTRL_OFFSET, 32'h0000_0002);
        make_frame(hdrs[0], 2, 20);
        run_frame(1'b0);
        check("rx bypass count", 32'(sum_cnt), 32'h0000_0000);
        // Deliberate change inside a frame: the frame keeps its old settings
        reg_wr(CTRL_OFFSET, 32'h0000_0001);
        make_frame(hdrs[5], 6, 20);
        fork
            run_frame(1'b0);
            begin
                repeat (6) @(posedge clk_sys);
                reg_wr(CTRL_OFFSET, 32'h0001_0002);
            end
        join
        check("rx mid change count", 32'(sum_cnt), 32'h0000_0006);
        run_frame(1'b0);
        check("rx new setting count", 32'(sum_cnt), 32'h0000_0000);
        reg_rd(STATUS_OFFSET, rd);
        check("unsafe flag", rd & 32'h0000_0100, 32'h0000_0100);
        make_frame(hdrs[0], 2, 16);
        fork
            run_frame(1'b1);
            begin
                repeat (6) @(posedge clk_sys);
                reg_wr(CTRL_OFFSET, 32'h0000_0000);
            end
        join
        check("tx insert count", 32'(ins_cnt), 32'h0000_0010);
        run_frame(1'b1);
        check("tx bypass count", 32'(ins_cnt), 32'h0000_0000);
        reg_wr(STATUS_OFFSET, 32'h0000_0100);
        reg_rd(STATUS_OFFSET, rd);
        check("unsafe clear", rd & 32'h0000_0100, 32'h0000_0000);
        for (int k = 0; k < 4; k++) begin
            reg_rd(RX_FRAMES_OFFSET + 12'(4 * k), rd);
            check("counter", rd, counts[k]);
        end
        summarize();
    end
endmodule // checksum_offload_control_test
